// ===== src/wake_ctl_pkg.sv
package wake_ctl_pkg;

  // ***********************************************************
  // Register location and layout
  // ***********************************************************
  localparam logic [2:0]  REG_ID_VALUE     = 3'h2;  // Address field 010
  localparam int          REG_ID_MSB       = 15;
  localparam int          REG_ID_LSB       = 13;
  localparam int          WRITE_LOCK_BIT   = 12;
  localparam int          MAIN_UV_EN_BIT   = 11;
  localparam int          XCVR_UV_EN_BIT   = 10;
  localparam int          LIN_A_STB_BIT    = 9;
  localparam int          LIN_B_STB_BIT    = 8;
  localparam int          WAKE_A_CTL_LSB   = 6;
  localparam int          WAKE_B_CTL_LSB   = 4;
  localparam int          FRAME_BITS       = 16;
  localparam logic [4:0]  FRAME_BITS_CNT   = 5'h10;

  // ***********************************************************
  // Power-on values
  // ***********************************************************
  localparam logic        WRITE_LOCK_RST   = 1'b0;
  localparam logic        UV_EN_RST        = 1'b0;
  localparam logic        LIN_STB_RST      = 1'b0;
  localparam logic [1:0]  WAKE_CTL_RST     = 2'h0;

  // ***********************************************************
  // Operating mode codes
  // ***********************************************************
  localparam logic [1:0]  MODE_STANDBY     = 2'h0;
  localparam logic [1:0]  MODE_SLEEP       = 2'h1;
  localparam logic [1:0]  MODE_NORMAL_XOFF = 2'h2;
  localparam logic [1:0]  MODE_NORMAL_XON  = 2'h3;

  // Transceiver state, one-hot
  typedef enum logic [2:0] {
    LIN_OFF      = 3'h1,
    LIN_ACTIVE   = 3'h2,
    LIN_LOWPOWER = 3'h4
  } lin_state_t;

endpackage

// ===== src/pin_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

// ***********************************************************
// Two-stage synchroniser with edge detection
// ***********************************************************
module pin_sync_edge (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  input  wire logic i_reset_level,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = i_pin;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // Reset to zero; the idle level is applied at o_level instead,
  // since an async reset may only load constants
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edges are seen only between the two settled stages
  assign o_level = st_r.sync ^ i_reset_level;
  assign o_rise  = (st_r.sync & ~st_r.prev) ^ 1'b0;
  assign o_fall  = ~st_r.sync & st_r.prev;

endmodule

`default_nettype wire

// ===== src/wake_interrupt_standby_control.sv
`timescale 1ns/100ps
`default_nettype none

module wake_interrupt_standby_control
  import wake_ctl_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  // Serial register interface
  input  wire logic               i_spi_sck,
  input  wire logic               i_spi_cs_n,
  input  wire logic               i_spi_mosi,
  output logic                    o_spi_miso,
  output logic                    o_spi_miso_oe_n,
  // Chip operating mode, from the mode register
  input  wire logic [1:0]         i_operating_mode_field,
  // Event sources (pins or analog comparators)
  input  wire logic               i_main_uv_warn,
  input  wire logic               i_xcvr_uv_warn,
  input  wire logic               i_wake_a,
  input  wire logic               i_wake_b,
  input  wire logic               i_lin_a_bus_wake,
  input  wire logic               i_lin_b_bus_wake,
  // Transceiver control
  output wake_ctl_pkg::lin_state_t o_lin_a_state,
  output wake_ctl_pkg::lin_state_t o_lin_b_state,
  output logic                    o_lin_a_wake_det_en,
  output logic                    o_lin_b_wake_det_en,
  output logic                    o_lin_a_wake_flag_clr,
  output logic                    o_lin_b_wake_flag_clr,
  output logic                    o_xcvr_regulator_on,
  // Interrupt requests, one-cycle pulses
  output logic                    o_main_uv_irq_req,
  output logic                    o_xcvr_uv_irq_req,
  output logic                    o_wake_a_irq_req,
  output logic                    o_wake_b_irq_req,
  output logic                    o_lin_a_wake_irq_req,
  output logic                    o_lin_b_wake_irq_req
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic        write_lock;
    logic        main_uv_en;
    logic        xcvr_uv_en;
    logic        lin_a_stb;
    logic        lin_b_stb;
    logic [1:0]  wake_a_ctl;
    logic [1:0]  wake_b_ctl;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0]  bit_cnt;
    logic        miso;
    logic        miso_oe_n;
    lin_state_t  lin_a_state;
    lin_state_t  lin_b_state;
    logic        lin_a_det;
    logic        lin_b_det;
    logic        lin_a_clr;
    logic        lin_b_clr;
    logic        xreg_on;
    logic [5:0]  irq;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic [NPIN-1:0] pin_idle;

  assign pin_raw  = {i_lin_b_bus_wake, i_lin_a_bus_wake, i_wake_b,
                     i_wake_a, i_xcvr_uv_warn, i_main_uv_warn,
                     i_spi_mosi, i_spi_cs_n, i_spi_sck};
  // Chip select idles high so reset never looks like a frame start
  assign pin_idle = 9'h002;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      pin_sync_edge u_sync (
        .i_clk         (i_clk),
        .i_reset_n     (i_reset_n),
        .i_pin         (pin_raw[gi] ^ pin_idle[gi]),
        .i_reset_level (pin_idle[gi]),
        .o_level       (pin_lvl[gi]),
        .o_rise        (pin_rise[gi]),
        .o_fall        (pin_fall[gi])
      );
    end
  endgenerate

  logic sck_rise;
  logic sck_fall;
  logic cs_active;
  logic cs_start;
  logic cs_end;
  logic mosi;

  assign sck_rise  = pin_rise[0];
  assign sck_fall  = pin_fall[0];
  assign cs_active = ~pin_lvl[1];
  // Inverted through the idle mapping: rise of stored value = cs falls
  assign cs_start  = pin_rise[1];
  assign cs_end    = pin_fall[1];
  assign mosi      = pin_lvl[2];

  // ***********************************************************
  // Register read image
  // ***********************************************************
  logic [15:0] read_word;
  logic        is_normal;

  always_comb begin
    read_word = 16'h0000;
    read_word[REG_ID_MSB:REG_ID_LSB] = REG_ID_VALUE;
    read_word[WRITE_LOCK_BIT] = st_r.write_lock;
    read_word[MAIN_UV_EN_BIT] = st_r.main_uv_en;
    read_word[XCVR_UV_EN_BIT] = st_r.xcvr_uv_en;
    read_word[LIN_A_STB_BIT]  = st_r.lin_a_stb;
    read_word[LIN_B_STB_BIT]  = st_r.lin_b_stb;
    read_word[WAKE_A_CTL_LSB +: 2] = st_r.wake_a_ctl;
    read_word[WAKE_B_CTL_LSB +: 2] = st_r.wake_b_ctl;
  end

  // Both Normal codes share the upper mode bit
  assign is_normal = (i_operating_mode_field == MODE_NORMAL_XOFF) ||
                     (i_operating_mode_field == MODE_NORMAL_XON);

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;

    // Frame shifting: sample on rising clock, shift out on falling
    if (cs_start) begin
      st_nxt.tx_shift  = read_word;
      st_nxt.bit_cnt   = 5'h00;
      st_nxt.miso      = read_word[FRAME_BITS-1];
      st_nxt.miso_oe_n = 1'b0;
    end else if (cs_active && sck_rise) begin
      st_nxt.rx_shift = {st_r.rx_shift[14:0], mosi};
      // Saturate at all ones so a long frame never reads as exactly 16
      if (st_r.bit_cnt != '1) begin
        st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
      end
    end else if (cs_active && sck_fall) begin
      st_nxt.tx_shift = {st_r.tx_shift[14:0], 1'b0};
      st_nxt.miso     = st_r.tx_shift[14];
    end

    // Commit only full frames for this address while unlocked;
    // a short or long frame is dropped to avoid a half-written word
    if (cs_end) begin
      st_nxt.miso_oe_n = 1'b1;
      if (st_r.bit_cnt == FRAME_BITS_CNT && !st_r.write_lock &&
          st_r.rx_shift[REG_ID_MSB:REG_ID_LSB] == REG_ID_VALUE) begin
        st_nxt.write_lock = st_r.rx_shift[WRITE_LOCK_BIT];
        st_nxt.main_uv_en = st_r.rx_shift[MAIN_UV_EN_BIT];
        st_nxt.xcvr_uv_en = st_r.rx_shift[XCVR_UV_EN_BIT];
        st_nxt.lin_a_stb  = st_r.rx_shift[LIN_A_STB_BIT];
        st_nxt.lin_b_stb  = st_r.rx_shift[LIN_B_STB_BIT];
        st_nxt.wake_a_ctl = st_r.rx_shift[WAKE_A_CTL_LSB +: 2];
        st_nxt.wake_b_ctl = st_r.rx_shift[WAKE_B_CTL_LSB +: 2];
      end
    end

    // LIN A standby decode
    if (st_r.lin_a_stb) begin
      st_nxt.lin_a_state = LIN_LOWPOWER;
    end else if (is_normal) begin
      st_nxt.lin_a_state = LIN_ACTIVE;
    end else begin
      st_nxt.lin_a_state = LIN_OFF;
    end
    st_nxt.lin_a_det = st_r.lin_a_stb;
    st_nxt.lin_a_clr = ~st_r.lin_a_stb & is_normal;

    // LIN B standby decode
    if (st_r.lin_b_stb) begin
      st_nxt.lin_b_state = LIN_LOWPOWER;
    end else if (is_normal) begin
      st_nxt.lin_b_state = LIN_ACTIVE;
    end else begin
      st_nxt.lin_b_state = LIN_OFF;
    end
    st_nxt.lin_b_det = st_r.lin_b_stb;
    st_nxt.lin_b_clr = ~st_r.lin_b_stb & is_normal;

    st_nxt.xreg_on = (i_operating_mode_field == MODE_NORMAL_XON);

    // Interrupt requests; one pulse per qualifying edge
    st_nxt.irq[0] = st_r.main_uv_en & pin_rise[3];
    st_nxt.irq[1] = st_r.xcvr_uv_en & pin_rise[4];
    st_nxt.irq[2] = (st_r.wake_a_ctl[0] & pin_rise[5]) |
                    (st_r.wake_a_ctl[1] & pin_fall[5]);
    // Code 11 sets both enables, so both edges fire
    st_nxt.irq[3] = (st_r.wake_b_ctl[0] & pin_rise[6]) |
                    (st_r.wake_b_ctl[1] & pin_fall[6]);
    st_nxt.irq[4] = st_r.lin_a_stb & pin_rise[7];
    st_nxt.irq[5] = st_r.lin_b_stb & pin_rise[8];
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r             <= '0;
      st_r.write_lock  <= WRITE_LOCK_RST;
      st_r.main_uv_en  <= UV_EN_RST;
      st_r.xcvr_uv_en  <= UV_EN_RST;
      st_r.lin_a_stb   <= LIN_STB_RST;
      st_r.lin_b_stb   <= LIN_STB_RST;
      st_r.wake_a_ctl  <= WAKE_CTL_RST;
      st_r.wake_b_ctl  <= WAKE_CTL_RST;
      st_r.miso_oe_n   <= 1'b1;
      st_r.lin_a_state <= LIN_OFF;
      st_r.lin_b_state <= LIN_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign o_spi_miso            = st_r.miso;
  assign o_spi_miso_oe_n       = st_r.miso_oe_n;
  assign o_lin_a_state         = st_r.lin_a_state;
  assign o_lin_b_state         = st_r.lin_b_state;
  assign o_lin_a_wake_det_en   = st_r.lin_a_det;
  assign o_lin_b_wake_det_en   = st_r.lin_b_det;
  assign o_lin_a_wake_flag_clr = st_r.lin_a_clr;
  assign o_lin_b_wake_flag_clr = st_r.lin_b_clr;
  assign o_xcvr_regulator_on   = st_r.xreg_on;
  assign o_main_uv_irq_req     = st_r.irq[0];
  assign o_xcvr_uv_irq_req     = st_r.irq[1];
  assign o_wake_a_irq_req      = st_r.irq[2];
  assign o_wake_b_irq_req      = st_r.irq[3];
  assign o_lin_a_wake_irq_req  = st_r.irq[4];
  assign o_lin_b_wake_irq_req  = st_r.irq[5];

endmodule

`default_nettype wire

// ===== tb/spi_host.sv
`timescale 1ns/100ps
`default_nettype none

// ***********************************************************
// Host controller on the serial register port
// ***********************************************************
module spi_host (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi
);
  // Idle: clock low, deselected
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One frame; phases of 5 cycles clear the 3-cycle sync delay
  task automatic xfer(input logic [15:0] d, output logic [15:0] r);
    @(posedge i_clk) o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      o_mosi <= d[i];
      repeat (5) @(posedge i_clk);
      o_sck <= 1'b1;
      r[i] = i_miso;  // Stable since the last fall
      repeat (5) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~d[0];  // Released line must not hold stale data
    repeat (8) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/wake_ctl_sva.sv
`timescale 1ns/100ps
`default_nettype none

// ***********************************************************
// Port checks of standby decode and request gating
// ***********************************************************
module wake_ctl_sva
  import wake_ctl_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic [1:0]               i_operating_mode_field,
  input  wire wake_ctl_pkg::lin_state_t o_lin_a_state,
  input  wire wake_ctl_pkg::lin_state_t o_lin_b_state,
  input  wire logic                     o_lin_a_wake_det_en,
  input  wire logic                     o_lin_b_wake_det_en,
  input  wire logic                     o_lin_a_wake_flag_clr,
  input  wire logic                     o_lin_b_wake_flag_clr,
  input  wire logic                     o_xcvr_regulator_on,
  input  wire logic                     o_main_uv_irq_req,
  input  wire logic                     o_lin_a_wake_irq_req,
  input  wire logic                     o_lin_b_wake_irq_req
);
  logic [1:0] up_r;

  // Skip two edges after reset: the first still shows reset values
  // while $past already sees the mode, since outputs lag by one cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up_r <= 2'h0;
    end else begin
      up_r <= {up_r[0], 1'b1};
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!up_r[1]);

  a_lin_a_low: assert property (
    o_lin_a_wake_det_en |-> o_lin_a_state == LIN_LOWPOWER)
    else $error("lin a not lowpower");
  a_lin_a_active: assert property (
    !o_lin_a_wake_det_en && $past(i_operating_mode_field[1])
    |-> o_lin_a_state == LIN_ACTIVE && o_lin_a_wake_flag_clr)
    else $error("lin a not active");
  a_lin_a_off: assert property (
    !o_lin_a_wake_det_en && !$past(i_operating_mode_field[1])
    |-> o_lin_a_state == LIN_OFF && !o_lin_a_wake_flag_clr)
    else $error("lin a not off");
  a_lin_b_low: assert property (
    o_lin_b_wake_det_en |-> o_lin_b_state == LIN_LOWPOWER)
    else $error("lin b not lowpower");
  a_lin_b_decode: assert property (
    !o_lin_b_wake_det_en |-> o_lin_b_wake_flag_clr ==
    $past(i_operating_mode_field[1]) && o_lin_b_state ==
    ($past(i_operating_mode_field[1]) ? LIN_ACTIVE : LIN_OFF))
    else $error("lin b decode wrong");
  a_xreg_mode: assert property (
    o_xcvr_regulator_on ==
    ($past(i_operating_mode_field) == MODE_NORMAL_XON))
    else $error("regulator enable wrong");
  a_uv_pulse: assert property (
    o_main_uv_irq_req |=> !o_main_uv_irq_req)
    else $error("uv request too long");
  a_lin_a_irq: assert property (
    o_lin_a_wake_irq_req |-> o_lin_a_wake_det_en)
    else $error("lin a request while off");
  a_lin_b_irq: assert property (
    o_lin_b_wake_irq_req |-> o_lin_b_wake_det_en)
    else $error("lin b request while off");

  c_uv_irq: cover property (o_main_uv_irq_req);
  c_lin_irq: cover property (o_lin_a_wake_irq_req);
  c_xreg_on: cover property (o_xcvr_regulator_on);
endmodule

bind wake_interrupt_standby_control wake_ctl_sva u_sva (
  .i_clk, .i_reset_n, .i_operating_mode_field, .o_lin_a_state,
  .o_lin_b_state, .o_lin_a_wake_det_en, .o_lin_b_wake_det_en,
  .o_lin_a_wake_flag_clr, .o_lin_b_wake_flag_clr, .o_xcvr_regulator_on,
  .o_main_uv_irq_req, .o_lin_a_wake_irq_req, .o_lin_b_wake_irq_req);
`default_nettype wire

// ===== tb/test_wake_interrupt_standby_control.sv
`timescale 1ns/100ps
`default_nettype none

// ***********************************************************
// Self-checking bench
// ***********************************************************
module test_wake_interrupt_standby_control;
  import wake_ctl_pkg::*;
  logic            i_clk;
  logic            i_reset_n = 1'b0;
  logic [1:0]      mode = 2'h0;
  logic [5:0]      ev = 6'h0;
  wire logic       sck, cs_n, mosi, miso, oe_n;
  wire logic [5:0] irq;
  wire logic [4:0] lvl;
  lin_state_t      st_a, st_b;
  logic [15:0]     q;
  int              n_mismatch = 0, check_count = 0, cyc = 0;

  spi_host host (.i_clk(i_clk), .i_miso(miso), .o_sck(sck),
    .o_cs_n(cs_n), .o_mosi(mosi));
  wake_interrupt_standby_control dut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n),
    .i_operating_mode_field(mode), .i_main_uv_warn(ev[0]),
    .i_xcvr_uv_warn(ev[1]), .i_wake_a(ev[2]), .i_wake_b(ev[3]),
    .i_lin_a_bus_wake(ev[4]), .i_lin_b_bus_wake(ev[5]),
    .o_lin_a_state(st_a), .o_lin_b_state(st_b),
    .o_lin_a_wake_det_en(lvl[4]), .o_lin_b_wake_det_en(lvl[3]),
    .o_lin_a_wake_flag_clr(lvl[2]), .o_lin_b_wake_flag_clr(lvl[1]),
    .o_xcvr_regulator_on(lvl[0]), .o_main_uv_irq_req(irq[0]),
    .o_xcvr_uv_irq_req(irq[1]), .o_wake_a_irq_req(irq[2]),
    .o_wake_b_irq_req(irq[3]), .o_lin_a_wake_irq_req(irq[4]),
    .o_lin_b_wake_irq_req(irq[5]));

  // Free-running 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_reg(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_num(string nm, int e, int g);
    check_count++;
    if (g != e) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Drive one event edge and count request pulses after it
  task automatic ev_hit(int k, logic lv, int e);
    int n;
    n = 0;
    @(posedge i_clk) ev[k] <= lv;
    repeat (10) begin
      @(posedge i_clk);
      #1;
      if (irq[k] === 1'b1) n++;
    end
    check_num($sformatf("irq%0d", k), e, n);
  endtask

  task automatic t_lin_modes();
    lin_state_t es;
    for (int s = 0; s < 2; s++) begin
      host.xfer(s ? 16'h4300 : 16'h4000, q);
      for (int m = 0; m < 4; m++) begin
        @(posedge i_clk) mode <= m[1:0];
        repeat (3) @(posedge i_clk);
        #1;
        es = s ? LIN_LOWPOWER : (m > 1 ? LIN_ACTIVE : LIN_OFF);
        check_reg("lin",
          {5'h0, es, es, s[0], s[0], s == 0 && m > 1, s == 0 && m > 1,
          m == 3}, {5'h0, st_a, st_b, lvl});
      end
    end
  endtask

  task automatic t_uv();
    for (int s = 0; s < 2; s++) begin
      host.xfer(s ? 16'h4c00 : 16'h4000, q);
      for (int k = 0; k < 2; k++) begin
        ev_hit(k, 1'b1, s);
        ev_hit(k, 1'b0, 0);
      end
    end
  endtask

  task automatic t_wake();
    for (int c = 0; c < 4; c++) begin
      host.xfer(16'h4000 | 16'(c << 6 | c << 4), q);
      for (int k = 2; k < 4; k++) begin
        ev_hit(k, 1'b1, c & 1);
        ev_hit(k, 1'b0, c >> 1);
      end
    end
  endtask

  task automatic t_lin_wake();
    @(posedge i_clk) mode <= MODE_STANDBY;
    for (int s = 0; s < 2; s++) begin
      host.xfer(s ? 16'h4300 : 16'h4000, q);
      for (int k = 4; k < 6; k++) begin
        ev_hit(k, 1'b1, s);
        ev_hit(k, 1'b0, 0);
      end
    end
  endtask

  // Wrong identifier refused, then lock blocks later writes
  task automatic t_refuse_lock();
    host.xfer(16'h6800, q);
    host.xfer(16'h4300, q);
    check_reg("after bad id", 16'h4300, q);
    host.xfer(16'h5c00, q);
    host.xfer(16'h4300, q);
    check_reg("locked", 16'h5c00, q);
    host.xfer(16'h4000, q);
    check_reg("locked again", 16'h5c00, q);
  endtask

  // Reset in mid-run is the only way out of the lock
  task automatic t_reset_again();
    @(posedge i_clk) i_reset_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    host.xfer(16'h4000, q);
    check_reg("image after reset", 16'h4000, q);
  endtask

  // Hang guard, well above the roughly 3600 cycles needed
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    // Output enable must be low while the frame is open
    fork
      host.xfer(16'h4000, q);
      begin
        repeat (10) @(posedge i_clk);
        #1;
        check_reg("oe in frame", 16'h0000, 16'(oe_n));
      end
    join
    check_reg("reset image", 16'h4000, q);
    check_reg("oe idle", 16'h0001, 16'(oe_n));
    t_lin_modes();
    t_uv();
    t_wake();
    t_lin_wake();
    t_refuse_lock();
    t_reset_again();
    finish_test();
  end
endmodule
`default_nettype wire
